// ==== cmd_decoder_defs.vh ====
// Constants for the counter command decoder: opcode fields, codes and reset values.
// Included by bare name from the design files; definitions only.
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH
`define CMD_W            8
`define NUM_CNT          5
`define OP_HI            7
`define OP_LO            5
`define OP_POINTER       3'h0
`define OP_ARM           3'h1
`define OP_LOAD          3'h2
`define OP_LOAD_ARM      3'h3
`define OP_DISARM_SAVE   3'h4
`define OP_SAVE          3'h5
`define OP_DISARM        3'h6
`define OP_SINGLE        3'h7
`define SUB_HI           4
`define SUB_LO           3
`define SUB_CLR_TOGGLE   2'h0
`define SUB_SET_TOGGLE   2'h1
`define SUB_STEP         2'h2
`define SUB_SPECIAL      2'h3
`define NUM_HI           2
`define NUM_LO           0
`define NUM_MIN          3'h1
`define NUM_MAX          3'h5
`define GRP_BAD_A        3'h0
`define GRP_BAD_B        3'h6
`define ELEM_HI          4
`define ELEM_LO          3
`define LOW_SEQ          3'h0
`define LOW_FREQUENCY_OUTPUT         3'h6
`define LOW_WIDE         3'h7
`define SPC_PREF_ON      3'h0
`define SPC_PREF_OFF     3'h1
`define SPC_MRESET       3'h7
`define PTR_RST          5'h00
`define MASK_ZERO        5'h00
`endif

// ==== counter_lane.v ====
// One counter's control lane: arm state, pending disarm and the reload selector.
// Assumes the terminal-count level comes from the counter datapath on the same clock.
`timescale 1ns/10ps
`include "cmd_decoder_defs.vh"
module counter_lane (
    input  wire i_clk,
    input  wire i_rst_b,
    input  wire i_arm,
    input  wire i_disarm,
    input  wire i_load,
    input  wire i_step,
    input  wire i_master_reset,
    input  wire i_terminal_count,
    input  wire i_reload_taken,
    output reg  o_armed,
    output reg  o_disarm_pending,
    output reg  o_reload_from_load
);
    // Leaving terminal count happens on a source edge, a load or a step.
    wire leave_tc = i_reload_taken | i_load | i_step;
    wire disarm_now = i_disarm | o_disarm_pending;

    // Arm wins over a disarm in the same command, as load-and-arm negates a disarm.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_armed            <= 1'b0;
            o_disarm_pending   <= 1'b0;
            o_reload_from_load <= 1'b0;
        end else if (i_master_reset) begin
            o_armed            <= 1'b0;
            o_disarm_pending   <= 1'b0;
            o_reload_from_load <= 1'b0;
        end else begin
            if (i_arm) begin
                o_armed          <= 1'b1;
                o_disarm_pending <= 1'b0;
            end else if (disarm_now && i_terminal_count && !leave_tc) begin
                o_disarm_pending <= 1'b1;
            end else if (disarm_now) begin
                o_armed          <= 1'b0;
                o_disarm_pending <= 1'b0;
            end
            // Arming resets the selector so the first reload comes from hold.
            if (i_arm)
                o_reload_from_load <= 1'b0;
            else if (i_reload_taken)
                o_reload_from_load <= ~o_reload_from_load;
        end
    end
endmodule

// ==== counter_command_decoder.v ====
// Command decoder for a five-counter timing controller.
// Assumes the control-port write strobe and byte are synchronous to i_clk.
`timescale 1ns/10ps
`include "cmd_decoder_defs.vh"
module counter_command_decoder #(
    parameter NCNT = `NUM_CNT
) (
    input  wire            i_clk,
    input  wire            i_rst_b,
    input  wire            i_cmd_write,
    input  wire [7:0]      i_cmd_data,
    input  wire [NCNT-1:0] i_terminal_count,
    input  wire [NCNT-1:0] i_reload_taken,
    input  wire [NCNT-1:0] i_count_direction_bit,
    output reg  [7:0]      o_command_entry,
    output reg  [NCNT-1:0] o_load_pulse,
    output reg  [NCNT-1:0] o_save_pulse,
    output reg  [NCNT-1:0] o_step_up_pulse,
    output reg  [NCNT-1:0] o_step_down_pulse,
    output wire [NCNT-1:0] o_armed,
    output wire [NCNT-1:0] o_disarm_pending,
    output wire [NCNT-1:0] o_reload_from_load,
    output reg  [NCNT-1:0] o_toggle_state,
    output reg  [1:0]      o_element_bits,
    output reg  [2:0]      o_group_bits,
    output reg             o_byte_pointer,
    output reg             o_pointer_load_pulse,
    output reg             o_pointer_sequencing_disable,
    output reg             o_freq_out_gate_off,
    output reg             o_wide_bus_select,
    output reg             o_write_prefetch,
    output reg             o_master_reset_pulse
);
    // Stage one: hold the written byte and a one-cycle decode strobe.
    reg cmd_valid_r;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_command_entry <= 8'h00;
            cmd_valid_r     <= 1'b0;
        end else begin
            cmd_valid_r <= i_cmd_write;
            if (i_cmd_write)
                o_command_entry <= i_cmd_data;
        end
    end

    // Field views of the latched byte.
    wire [2:0]      op_field  = o_command_entry[`OP_HI:`OP_LO];
    wire [1:0]      sub_field = o_command_entry[`SUB_HI:`SUB_LO];
    wire [2:0]      low_field = o_command_entry[`NUM_HI:`NUM_LO];
    wire [NCNT-1:0] sel_mask  = o_command_entry[NCNT-1:0];
    wire            num_ok    = (low_field >= `NUM_MIN) && (low_field <= `NUM_MAX);
    wire            is_single = cmd_valid_r && (op_field == `OP_SINGLE);

    // One-hot decode of the counter number; out-of-range numbers select none.
    reg [NCNT-1:0] num_onehot;
    integer k;
    always @* begin
        num_onehot = {NCNT{1'b0}};
        for (k = 0; k < NCNT; k = k + 1)
            if (num_ok && (low_field == k + 1))
                num_onehot[k] = 1'b1;
    end

    // Mask-command decode; all selected lanes see their strobe in the same cycle.
    reg [NCNT-1:0] arm_m;
    reg [NCNT-1:0] disarm_m;
    reg [NCNT-1:0] load_m;
    reg [NCNT-1:0] save_m;
    reg [NCNT-1:0] step_m;
    reg [NCNT-1:0] tog_set_m;
    reg [NCNT-1:0] tog_clr_m;
    reg            ptr_load;
    reg            mreset;
    always @* begin
        arm_m     = {NCNT{1'b0}};
        disarm_m  = {NCNT{1'b0}};
        load_m    = {NCNT{1'b0}};
        save_m    = {NCNT{1'b0}};
        step_m    = {NCNT{1'b0}};
        tog_set_m = {NCNT{1'b0}};
        tog_clr_m = {NCNT{1'b0}};
        ptr_load  = 1'b0;
        mreset    = 1'b0;
        if (cmd_valid_r) begin
            case (op_field)
                `OP_POINTER: begin
                    // Groups 000 and 110 are reserved and leave the pointer alone.
                    ptr_load = (low_field != `GRP_BAD_A) && (low_field != `GRP_BAD_B);
                end
                `OP_ARM: begin
                    arm_m = sel_mask;
                end
                `OP_LOAD: begin
                    load_m = sel_mask;
                end
                `OP_LOAD_ARM: begin
                    load_m = sel_mask;
                    arm_m  = sel_mask;
                end
                `OP_DISARM_SAVE: begin
                    disarm_m = sel_mask;
                    save_m   = sel_mask;
                end
                `OP_SAVE: begin
                    save_m = sel_mask;
                end
                `OP_DISARM: begin
                    disarm_m = sel_mask;
                end
                `OP_SINGLE: begin
                    case (sub_field)
                        `SUB_SET_TOGGLE: tog_set_m = num_onehot;
                        `SUB_CLR_TOGGLE: tog_clr_m = num_onehot;
                        `SUB_STEP:       step_m    = num_onehot;
                        `SUB_SPECIAL:    mreset    = (low_field == `SPC_MRESET);
                        default:         step_m    = {NCNT{1'b0}};
                    endcase
                end
                default: begin
                    ptr_load = 1'b0;
                end
            endcase
        end
    end

    // Datapath strobes are registered pulses, one cycle each.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_load_pulse         <= `MASK_ZERO;
            o_save_pulse         <= `MASK_ZERO;
            o_step_up_pulse      <= `MASK_ZERO;
            o_step_down_pulse    <= `MASK_ZERO;
            o_pointer_load_pulse <= 1'b0;
            o_master_reset_pulse <= 1'b0;
        end else begin
            o_load_pulse         <= load_m;
            o_save_pulse         <= save_m;
            o_step_up_pulse      <= step_m & i_count_direction_bit;
            o_step_down_pulse    <= step_m & ~i_count_direction_bit;
            o_pointer_load_pulse <= ptr_load;
            o_master_reset_pulse <= mreset;
        end
    end

    // Toggle flip-flops; master reset clears them as well.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_toggle_state <= `MASK_ZERO;
        else if (mreset)
            o_toggle_state <= `MASK_ZERO;
        else
            o_toggle_state <= (o_toggle_state | tog_set_m) & ~tog_clr_m;
    end

    // Data pointer fields; the byte pointer is set on each accepted load.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {o_element_bits, o_group_bits} <= `PTR_RST;
            o_byte_pointer                 <= 1'b0;
        end else if (ptr_load) begin
            o_element_bits <= o_command_entry[`ELEM_HI:`ELEM_LO];
            o_group_bits   <= low_field;
            o_byte_pointer <= 1'b1;
        end
    end

    // Master-mode bits. Special codes share the toggle sub-fields with counter
    // numbers 0, 6 and 7, which is why those numbers never reach a toggle flip-flop.
    wire spc_set = is_single && (sub_field == `SUB_SET_TOGGLE);
    wire spc_clr = is_single && (sub_field == `SUB_CLR_TOGGLE);
    wire spc_top = is_single && (sub_field == `SUB_SPECIAL);
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pointer_sequencing_disable <= 1'b0;
            o_freq_out_gate_off          <= 1'b0;
            o_wide_bus_select            <= 1'b0;
            o_write_prefetch             <= 1'b0;
        end else if (mreset) begin
            o_pointer_sequencing_disable <= 1'b0;
            o_freq_out_gate_off          <= 1'b0;
            o_wide_bus_select            <= 1'b0;
            o_write_prefetch             <= 1'b0;
        end else begin
            if ((spc_set || spc_clr) && low_field == `LOW_SEQ)
                o_pointer_sequencing_disable <= spc_set;
            if ((spc_set || spc_clr) && low_field == `LOW_FREQUENCY_OUTPUT)
                o_freq_out_gate_off <= spc_set;
            if ((spc_set || spc_clr) && low_field == `LOW_WIDE)
                o_wide_bus_select <= spc_set;
            if (spc_top && low_field == `SPC_PREF_ON)
                o_write_prefetch <= 1'b1;
            else if (spc_top && low_field == `SPC_PREF_OFF)
                o_write_prefetch <= 1'b0;
        end
    end

    // One control lane per counter.
    genvar g;
    generate
        for (g = 0; g < NCNT; g = g + 1) begin : lane
            counter_lane u_lane (
                .i_clk              (i_clk),
                .i_rst_b            (i_rst_b),
                .i_arm              (arm_m[g]),
                .i_disarm           (disarm_m[g]),
                .i_load             (load_m[g]),
                .i_step             (step_m[g]),
                .i_master_reset     (mreset),
                .i_terminal_count   (i_terminal_count[g]),
                .i_reload_taken     (i_reload_taken[g]),
                .o_armed            (o_armed[g]),
                .o_disarm_pending   (o_disarm_pending[g]),
                .o_reload_from_load (o_reload_from_load[g])
            );
        end
    endgenerate
endmodule

// ==== host_port_model.sv ====
// Behavioural host that writes command bytes into the decoder's control port.
// Assumes callers enter its tasks just after a rising edge of i_clk.
`timescale 1ns/10ps
module host_port_model (
    input  wire logic       i_clk,
    output logic            o_cmd_write,
    output logic [7:0]      o_cmd_data
);
    // The port starts idle; nothing is offered before reset is released.
    initial begin
        o_cmd_write = 1'b0;
        o_cmd_data  = 8'h00;
    end
    // One whole byte per strobe cycle, so back-to-back calls keep the strobe high.
    // Every byte is synchronous to i_clk, so load-and-arm is always safe here.
    task automatic write_byte(input logic [7:0] c);
        o_cmd_write <= 1'b1;
        o_cmd_data  <= c;
        @(posedge i_clk);
    endtask
    // A released port shows the inverted byte, so stale data never looks valid.
    task automatic idle_port;
        o_cmd_write <= 1'b0;
        o_cmd_data  <= ~o_cmd_data;
    endtask
endmodule

// ==== counter_command_decoder_sva.sv ====
// Concurrent checks on the command decoder's ports.
// Assumes effects of a byte taken at one edge are visible after the next edge.
`timescale 1ns/10ps
module counter_command_decoder_sva #(
    parameter NCNT = 5
) (
    input wire logic            i_clk,
    input wire logic            i_rst_b,
    input wire logic            i_cmd_write,
    input wire logic [7:0]      i_cmd_data,
    input wire logic [NCNT-1:0] i_terminal_count,
    input wire logic [NCNT-1:0] i_count_direction_bit,
    input wire logic [7:0]      o_command_entry,
    input wire logic [NCNT-1:0] o_load_pulse,
    input wire logic [NCNT-1:0] o_save_pulse,
    input wire logic [NCNT-1:0] o_step_up_pulse,
    input wire logic [NCNT-1:0] o_step_down_pulse,
    input wire logic [NCNT-1:0] o_armed,
    input wire logic [NCNT-1:0] o_disarm_pending,
    input wire logic [NCNT-1:0] o_reload_from_load,
    input wire logic [NCNT-1:0] o_toggle_state,
    input wire logic [1:0]      o_element_bits,
    input wire logic [2:0]      o_group_bits,
    input wire logic            o_byte_pointer,
    input wire logic            o_pointer_sequencing_disable,
    input wire logic            o_write_prefetch
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0]      d1, d2, d3;
    logic            v1, v2, v3;
    logic [NCNT-1:0] t1, t2, t3;
    // Delay the taken byte so each property sees it when its effect is due.
    // The decoder answers one edge after the byte is taken, so the third stage
    // is only two edges deep; stages one and two are the same one-edge copy.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {v1, v2, v3, d1, d2, d3, t1, t2, t3} <= '0;
        end else begin
            {v1, v2, v3} <= {i_cmd_write, i_cmd_write, v2};
            {d1, d2, d3} <= {i_cmd_data, i_cmd_data, d2};
            {t1, t2, t3} <= {i_terminal_count, i_terminal_count, t2};
        end
    end
    wire [4:0] m3  = d3[4:0];
    wire       n3  = d3[2:0] >= 3'h1 && d3[2:0] <= 3'h5;
    wire [4:0] oh3 = 5'h01 << (d3[2:0] - 3'h1);
    chk_entry_latch: assert property (i_cmd_write |=> o_command_entry == $past(i_cmd_data))
        else $error("command byte not latched");
    chk_arm_mask: assert property (v3 && d3[7:5] == 3'h1 |-> (o_armed & m3) == m3)
        else $error("arm missed a selected counter");
    chk_arm_selector: assert property (v3 && !d3[7] && d3[5] |-> (o_reload_from_load & m3) == 0)
        else $error("arm left reload selector set");
    chk_load_mask: assert property (v3 && d3[7:6] == 2'h1 |-> o_load_pulse == m3)
        else $error("load pulse differs from mask");
    chk_save_mask: assert property (v3 && d3[7:6] == 2'h2 |-> o_save_pulse == m3)
        else $error("save pulse differs from mask");
    chk_disarm_clear: assert property (v3 && d3[7:5] == 3'h6 && ((t1 | t2 | t3) & m3) == 0
        |-> (o_armed & m3) == 0)
        else $error("disarm left a counter armed");
    chk_step_dir: assert property (v3 && d3[7:3] == 5'h1E && n3
        |-> o_step_up_pulse == (oh3 & i_count_direction_bit)
            && o_step_down_pulse == (oh3 & ~i_count_direction_bit))
        else $error("step pulse wrong");
    chk_toggle_write: assert property (v3 && d3[7:4] == 4'hE && n3
        |-> o_toggle_state[d3[2:0] - 3'h1] == d3[3])
        else $error("toggle state wrong");
    chk_seq_bit: assert property (v3 && d3[7:4] == 4'hE && d3[2:0] == 3'h0
        |-> o_pointer_sequencing_disable == d3[3])
        else $error("sequencing bit wrong");
    chk_prefetch_bit: assert property (v3 && d3[7:1] == 7'h7C |-> o_write_prefetch == !d3[0])
        else $error("prefetch bit wrong");
    chk_pointer_load: assert property (v3 && d3[7:5] == 3'h0 && d3[2:0] != 3'h0 && d3[2:0] != 3'h6
        |-> {o_element_bits, o_group_bits, o_byte_pointer} == {d3[4:0], 1'b1})
        else $error("pointer load wrong");
    chk_pending_release: assert property (|o_disarm_pending && i_terminal_count == 0
        |-> ##[1:2] o_disarm_pending == 0 && (o_armed & $past(o_disarm_pending)) == 0)
        else $error("pending disarm not released");
    cover property (v3 && d3[7:5] == 3'h1);
    cover property ($rose(|o_disarm_pending));
    cover property (|o_step_up_pulse);
endmodule
bind counter_command_decoder counter_command_decoder_sva #(.NCNT(NCNT)) chk_u (
    .i_clk, .i_rst_b, .i_cmd_write, .i_cmd_data, .i_terminal_count, .i_count_direction_bit,
    .o_command_entry, .o_load_pulse, .o_save_pulse, .o_step_up_pulse, .o_step_down_pulse,
    .o_armed, .o_disarm_pending, .o_reload_from_load, .o_toggle_state, .o_element_bits,
    .o_group_bits, .o_byte_pointer, .o_pointer_sequencing_disable, .o_write_prefetch
);

// ==== counter_command_decoder_tb_top.sv ====
// Self-checking bench: every command byte is swept, then random legal bytes follow.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`define CMP(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module counter_command_decoder_tb_top;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [4:0]  tc = 5'h00, reload = 5'h00, dir = 5'h00;
    logic [4:0]  e_arm = 5'h00, e_tog = 5'h00;
    logic [3:0]  e_mode = 4'h0;
    logic [5:0]  e_ptr = 6'h00;
    logic [2:0]  taken = 3'h0;
    logic [41:0] notes[$];
    int          n_errors = 0, checked = 0, cyc = 0;
    bit          rnd_on = 1'b0;
    wire         wr, bp, pl, seq, fo, wb, pf, mr;
    wire  [7:0]  data;
    wire  [4:0]  ld, sv, up, dn, armed, pend, tog;
    wire  [1:0]  el;
    wire  [2:0]  gr;
    wire  [41:0] seen = {armed, tog, ld, sv, up, dn, seq, fo, wb, pf, el, gr, bp, pl, mr};
    host_port_model host_u (.i_clk(i_clk), .o_cmd_write(wr), .o_cmd_data(data));
    counter_command_decoder dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_write(wr), .i_cmd_data(data),
        .i_terminal_count(tc), .i_reload_taken(reload), .i_count_direction_bit(dir),
        .o_command_entry(), .o_load_pulse(ld), .o_save_pulse(sv), .o_step_up_pulse(up),
        .o_step_down_pulse(dn), .o_armed(armed), .o_disarm_pending(pend),
        .o_reload_from_load(), .o_toggle_state(tog), .o_element_bits(el), .o_group_bits(gr),
        .o_byte_pointer(bp), .o_pointer_load_pulse(pl), .o_pointer_sequencing_disable(seq),
        .o_freq_out_gate_off(fo), .o_wide_bus_select(wb), .o_write_prefetch(pf),
        .o_master_reset_pulse(mr));
    // Clock at 10 MHz.
    initial forever #50 i_clk = ~i_clk;
    task automatic end_of_test;
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reserved bytes; only the sweep sends them, on purpose.
    function automatic bit reserved(input logic [7:0] c);
        return (c[7:5] == 3'h0 && (c[2:0] == 3'h0 || c[2:0] == 3'h6))
            || (c[7:3] == 5'h1E && (c[2:0] == 3'h0 || c[2:0] > 3'h5))
            || (c[7:3] == 5'h1F && c[2:0] != 3'h0 && c[2:0] != 3'h1 && c[2:0] != 3'h7);
    endfunction
    // Works out the state after a byte, notes it, then hands the byte to the host.
    task automatic send(input logic [7:0] c);
        logic [4:0] m, oh, l, s, u, d;
        logic       p, r;
        m = c[4:0];
        oh = (c[2:0] >= 3'h1 && c[2:0] <= 3'h5) ? 5'h01 << (c[2:0] - 3'h1) : 5'h00;
        {l, s, u, d, p, r} = '0;
        case (c[7:5])
            3'h0: if (!reserved(c)) {e_ptr, p} = {c[4:0], 2'h3};
            3'h1: e_arm = e_arm | m;
            3'h2: l = m;
            3'h3: {l, e_arm} = {m, e_arm | m};
            3'h4, 3'h6: begin
                e_arm = e_arm & ~(m & ~tc);
                s = c[6] ? 5'h00 : m;
            end
            3'h5: s = m;
            default: case (c[4:3])
                2'h2: {u, d} = {oh & dir, oh & ~dir};
                2'h3: if (c[2:0] == 3'h7) {e_arm, e_tog, e_mode, r} = 15'h0001;
                      else if (c[2:1] == 2'h0) e_mode[0] = !c[0];
                default: case (c[2:0])
                    3'h0: e_mode[3] = c[3];
                    3'h6: e_mode[2] = c[3];
                    3'h7: e_mode[1] = c[3];
                    default: e_tog = c[3] ? e_tog | oh : e_tog & ~oh;
                endcase
            endcase
        endcase
        notes.push_back({e_arm, e_tog, l, s, u, d, e_mode, e_ptr, p, r});
        host_u.write_byte(c);
    endtask
    // Track taken bytes; random reload events; cut a hang short.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            taken <= 3'h0;
        end else begin
            taken <= {taken[1:0], wr};
            reload <= rnd_on ? 5'($urandom) : 5'h00;
            cyc <= cyc + 1;
            if (cyc == 3000) begin
                n_errors++;
                end_of_test();
            end
        end
    end
    // Each result shows one edge after its byte was taken; compare with the oldest note.
    always @(negedge i_clk) begin
        if (taken[1]) `CMP(seen, notes.pop_front())
    end
    initial begin
        logic [7:0] c;
        void'($urandom(25375));
        dir = 5'($urandom);
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < 256; i++) send(8'(i));
        rnd_on = 1'b1;
        repeat (300) begin
            c = 8'($urandom);
            if (!reserved(c)) send(c);
        end
        rnd_on = 1'b0;
        tc <= 5'h01;
        send(8'h21);
        send(8'hC1);
        host_u.idle_port();
        repeat (3) @(negedge i_clk);
        `CMP({armed[0], pend[0]}, 2'h3)
        tc <= 5'h00;
        repeat (3) @(negedge i_clk);
        `CMP({armed[0], pend[0]}, 2'h0)
        end_of_test();
    end
endmodule
